// ==== ocd_pkg.sv ====
// Constants and types shared by the output compare channel.
// Assumes a 32-bit APB bus and one 20 MHz clock.
package ocd_pkg;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CON1 = 8'h00;
   localparam logic [7:0] OFF_CON2 = 8'h04;
   localparam logic [7:0] OFF_PRI = 8'h08;
   localparam logic [7:0] OFF_SEC = 8'h0C;
   localparam logic [7:0] OFF_PER = 8'h10;
   localparam logic [7:0] OFF_CNT = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;

   // ==========================================================
   // First control register fields
   localparam int CON1_TSEL_LO = 10;
   localparam int CON1_POL = 5;
   localparam int CON1_CONT = 4;
   localparam int CON1_TRIGBEH = 3;
   localparam int CON1_MODE_LO = 0;
   localparam logic [15:0] CON1_MASK = 16'h1C3F;
   localparam logic [15:0] CON1_RST = 16'h0000;

   // ==========================================================
   // Second control register fields
   localparam int CON2_CASC = 8;
   localparam int CON2_TRIGSEL = 7;
   localparam int CON2_TRIGGER_STATUS_BIT = 6;
   localparam int CON2_SYNC_LO = 0;
   localparam logic [15:0] CON2_MASK = 16'h01DF;
   localparam logic [15:0] CON2_RST = 16'h0000;

   // ==========================================================
   // Status register fields
   localparam int STAT_FLAG = 0;
   localparam int STAT_PIN = 1;
   localparam int STAT_TRIG = 2;

   // ==========================================================
   // Field widths, codes and reset values
   localparam int TSEL_W = 3;
   localparam int MODE_W = 3;
   localparam int SYNC_W = 5;
   localparam int NUM_SYNC = 31;
   localparam int NUM_TB_PINS = 5;
   localparam logic [2:0] TSEL_PCLK = 3'h7;
   localparam logic [2:0] TSEL_LAST_PIN = 3'h4;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SINGLE = 3'h1;
   localparam logic [2:0] MODE_DOUBLE = 3'h2;
   localparam logic [2:0] MODE_TOGGLE = 3'h3;
   localparam logic [4:0] SYNC_NONE = 5'h00;
   localparam logic [15:0] PER_RST = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // ==========================================================
   // Compare sequence states
   typedef enum logic [1:0] {
      CS_WAIT,
      CS_ACTIVE,
      CS_DONE
   } ocd_cmp_state_t;

endpackage

// ==== ocd_edge_sync.sv ====
// Two-stage synchroniser with rising edge detect, one per bit.
// Assumes inputs are asynchronous levels from pins or other clocks.
`timescale 1ns/1ns
module ocd_edge_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] rise
);

   // ==========================================================
   // Synchroniser chain
   // First stage feeds only the second; edges are taken later
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign rise = sync_r & ~prev_r;

endmodule

// ==== ocd_channel.sv ====
// Output compare channel with its own 16-bit counter and APB registers.
// Assumes time base and sync sources arrive as asynchronous levels and
// that a cascade partner connects carry_out to carry_in.
`timescale 1ns/1ns
module ocd_channel #(
   parameter bit EVEN_CHANNEL = 1'b0,
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ocd_pkg::NUM_TB_PINS-1:0] time_base_src,
   input wire logic [ocd_pkg::NUM_SYNC-1:0] sync_src,
   input wire logic carry_in,
   output logic carry_out,
   output logic odd_channel_output,
   output logic channel_interrupt_flag,
   output logic [CNT_W-1:0] channel_counter
);

   // ==========================================================
   // State record
   typedef struct packed {
      logic [15:0] first_control_register;
      logic [15:0] second_control_register;
      logic [CNT_W-1:0] primary_compare_value;
      logic [CNT_W-1:0] secondary_compare_value;
      logic [CNT_W-1:0] timer_period_value;
      logic [CNT_W-1:0] cnt;
      ocd_pkg::ocd_cmp_state_t cmp;
      logic pin;
      logic flag;
      logic carry;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } ocd_state_t;

   ocd_state_t s_r;
   ocd_state_t s_nxt;

   // ==========================================================
   // Synchronised source edges
   logic [ocd_pkg::NUM_TB_PINS-1:0] tb_rise;
   logic [ocd_pkg::NUM_SYNC-1:0] sync_rise;
   logic carry_in_q;

   ocd_edge_sync #(
      .W(ocd_pkg::NUM_TB_PINS)
   ) u_tb_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(time_base_src),
      .rise(tb_rise)
   );

   ocd_edge_sync #(
      .W(ocd_pkg::NUM_SYNC)
   ) u_src_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(sync_src),
      .rise(sync_rise)
   );

   // Partner carry is already a one-cycle pulse on pclk, no sync needed
   assign carry_in_q = carry_in;

   // ==========================================================
   // Decoded configuration
   logic [ocd_pkg::TSEL_W-1:0] time_base_select;
   logic [ocd_pkg::MODE_W-1:0] mode_select_field;
   logic [ocd_pkg::SYNC_W-1:0] sync_source_select;
   logic trigger_select_bit;
   logic trigger_status_bit;
   logic trigger_behaviour_bit;
   logic cascade_enable;
   logic idle_level;
   logic continuous;

   assign time_base_select = s_r.first_control_register[
      ocd_pkg::CON1_TSEL_LO +: ocd_pkg::TSEL_W];
   assign mode_select_field = s_r.first_control_register[
      ocd_pkg::CON1_MODE_LO +: ocd_pkg::MODE_W];
   assign trigger_behaviour_bit =
      s_r.first_control_register[ocd_pkg::CON1_TRIGBEH];
   assign continuous = s_r.first_control_register[ocd_pkg::CON1_CONT];
   assign idle_level = s_r.first_control_register[ocd_pkg::CON1_POL];
   assign sync_source_select = s_r.second_control_register[
      ocd_pkg::CON2_SYNC_LO +: ocd_pkg::SYNC_W];
   assign trigger_select_bit =
      s_r.second_control_register[ocd_pkg::CON2_TRIGSEL];
   assign trigger_status_bit =
      s_r.second_control_register[ocd_pkg::CON2_TRIGGER_STATUS_BIT];
   assign cascade_enable = s_r.second_control_register[ocd_pkg::CON2_CASC];

   // ==========================================================
   // Time base tick and sync events
   logic tb_tick;
   logic sync_hit;
   logic sync_mode;
   logic trig_mode;

   always_comb begin
      tb_tick = 1'b0;
      if (cascade_enable && EVEN_CHANNEL) begin
         tb_tick = carry_in_q;
      end else if (time_base_select == ocd_pkg::TSEL_PCLK) begin
         tb_tick = 1'b1;
      end else if (time_base_select <= ocd_pkg::TSEL_LAST_PIN) begin
         tb_tick = tb_rise[time_base_select];
      end
   end

   always_comb begin
      sync_hit = 1'b0;
      if (sync_source_select != ocd_pkg::SYNC_NONE) begin
         sync_hit = sync_rise[sync_source_select - 5'h01];
      end
   end

   // Codes above the last pin other than the peripheral clock give no tick
   assign sync_mode = (sync_source_select != ocd_pkg::SYNC_NONE) &&
      !trigger_select_bit;
   assign trig_mode = (sync_source_select != ocd_pkg::SYNC_NONE) &&
      trigger_select_bit;

   // ==========================================================
   // Bus decode
   logic setup;
   logic wr_en;
   logic mapped;
   logic [31:0] rd_mux;
   logic [31:0] stat_word;

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && s_r.ready;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[ocd_pkg::STAT_FLAG] = s_r.flag;
      stat_word[ocd_pkg::STAT_PIN] = s_r.pin;
      stat_word[ocd_pkg::STAT_TRIG] = trigger_status_bit;
   end

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      if (paddr == ocd_pkg::OFF_CON1) begin
         rd_mux[15:0] = s_r.first_control_register;
      end else if (paddr == ocd_pkg::OFF_CON2) begin
         rd_mux[15:0] = s_r.second_control_register;
      end else if (paddr == ocd_pkg::OFF_PRI) begin
         rd_mux[CNT_W-1:0] = s_r.primary_compare_value;
      end else if (paddr == ocd_pkg::OFF_SEC) begin
         rd_mux[CNT_W-1:0] = s_r.secondary_compare_value;
      end else if (paddr == ocd_pkg::OFF_PER) begin
         rd_mux[CNT_W-1:0] = s_r.timer_period_value;
      end else if (paddr == ocd_pkg::OFF_CNT) begin
         rd_mux[CNT_W-1:0] = s_r.cnt;
      end else if (paddr == ocd_pkg::OFF_STAT) begin
         rd_mux = stat_word;
      end else begin
         mapped = 1'b0;
      end
   end

   // ==========================================================
   // Next state
   logic con1_wr;
   logic counting;
   logic wrap;
   logic pri_hit;
   logic sec_hit;
   logic flag_set;
   logic trig_set;
   logic [15:0] con2_wr_val;

   always_comb begin
      s_nxt = s_r;
      s_nxt.carry = 1'b0;
      con1_wr = 1'b0;
      flag_set = 1'b0;
      trig_set = 1'b0;
      con2_wr_val = pwdata[15:0] & ocd_pkg::CON2_MASK;

      // Bus answer: ready in the access cycle after each setup
      s_nxt.ready = setup;
      s_nxt.slverr = setup && !mapped;
      s_nxt.rdata = (setup && !pwrite) ? rd_mux : 32'h0000_0000;

      // Counter gating
      counting = tb_tick;
      if (trig_mode && !trigger_status_bit) begin
         counting = 1'b0;
      end
      wrap = counting && (s_r.cnt == s_r.timer_period_value);
      pri_hit = counting && (s_r.cnt == s_r.primary_compare_value);
      sec_hit = counting && (s_r.cnt == s_r.secondary_compare_value);

      if (mode_select_field == ocd_pkg::MODE_OFF) begin
         s_nxt.cnt = ocd_pkg::CNT_ZERO;
      end else if (sync_mode && sync_hit) begin
         s_nxt.cnt = ocd_pkg::CNT_ZERO;
      end else if (trig_mode && !trigger_status_bit) begin
         s_nxt.cnt = ocd_pkg::CNT_ZERO;
      end else if (wrap) begin
         s_nxt.cnt = ocd_pkg::CNT_ZERO;
         s_nxt.carry = 1'b1;
      end else if (counting) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end

      // Compare actions; codes with top bit set park the pin like off
      case (mode_select_field)
         ocd_pkg::MODE_SINGLE: begin
            if (s_r.cmp == ocd_pkg::CS_WAIT && pri_hit) begin
               s_nxt.pin = !idle_level;
               flag_set = 1'b1;
               s_nxt.cmp = continuous ? ocd_pkg::CS_ACTIVE :
                  ocd_pkg::CS_DONE;
            end else if (s_r.cmp == ocd_pkg::CS_ACTIVE && wrap) begin
               s_nxt.pin = idle_level;
               s_nxt.cmp = ocd_pkg::CS_WAIT;
            end
         end
         ocd_pkg::MODE_DOUBLE: begin
            if (s_r.cmp == ocd_pkg::CS_WAIT && pri_hit) begin
               s_nxt.pin = !idle_level;
               s_nxt.cmp = ocd_pkg::CS_ACTIVE;
            end else if (s_r.cmp == ocd_pkg::CS_ACTIVE && sec_hit) begin
               s_nxt.pin = idle_level;
               flag_set = 1'b1;
               s_nxt.cmp = continuous ? ocd_pkg::CS_WAIT :
                  ocd_pkg::CS_DONE;
            end
         end
         ocd_pkg::MODE_TOGGLE: begin
            if (pri_hit) begin
               s_nxt.pin = !s_r.pin;
               flag_set = 1'b1;
            end
         end
         default: begin
            // Off and the non-compare codes park the pin
            s_nxt.pin = idle_level;
            s_nxt.cmp = ocd_pkg::CS_WAIT;
         end
      endcase

      // Register writes take effect at the access edge
      if (wr_en) begin
         if (paddr == ocd_pkg::OFF_CON1) begin
            s_nxt.first_control_register =
               pwdata[15:0] & ocd_pkg::CON1_MASK;
            con1_wr = 1'b1;
         end else if (paddr == ocd_pkg::OFF_CON2) begin
            s_nxt.second_control_register = con2_wr_val;
         end else if (paddr == ocd_pkg::OFF_PRI) begin
            s_nxt.primary_compare_value = pwdata[CNT_W-1:0];
         end else if (paddr == ocd_pkg::OFF_SEC) begin
            s_nxt.secondary_compare_value = pwdata[CNT_W-1:0];
         end else if (paddr == ocd_pkg::OFF_PER) begin
            s_nxt.timer_period_value = pwdata[CNT_W-1:0];
         end else if (paddr == ocd_pkg::OFF_STAT) begin
            if (pwdata[ocd_pkg::STAT_FLAG]) begin
               s_nxt.flag = 1'b0;
            end
         end
      end

      // Rewriting the first control register re-arms a finished shot
      if (con1_wr) begin
         s_nxt.cmp = ocd_pkg::CS_WAIT;
         s_nxt.pin = pwdata[ocd_pkg::CON1_POL];
         if (pwdata[ocd_pkg::CON1_MODE_LO +: ocd_pkg::MODE_W] ==
            ocd_pkg::MODE_OFF) begin
            s_nxt.cnt = ocd_pkg::CNT_ZERO;
         end
      end

      // Trigger status: behaviour bit clears it on wrap, an event sets it
      if (trig_mode && trigger_behaviour_bit && wrap) begin
         s_nxt.second_control_register[ocd_pkg::CON2_TRIGGER_STATUS_BIT] = 1'b0;
      end
      trig_set = trig_mode && sync_hit;
      if (trig_set) begin
         s_nxt.second_control_register[ocd_pkg::CON2_TRIGGER_STATUS_BIT] = 1'b1;
      end

      // Hardware set wins over a same-cycle software clear
      if (flag_set) begin
         s_nxt.flag = 1'b1;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.first_control_register <= ocd_pkg::CON1_RST;
         s_r.second_control_register <= ocd_pkg::CON2_RST;
         s_r.primary_compare_value <= ocd_pkg::CNT_ZERO;
         s_r.secondary_compare_value <= ocd_pkg::CNT_ZERO;
         s_r.timer_period_value <= ocd_pkg::PER_RST;
         s_r.cnt <= ocd_pkg::CNT_ZERO;
         s_r.cmp <= ocd_pkg::CS_WAIT;
         s_r.pin <= 1'b0;
         s_r.flag <= 1'b0;
         s_r.carry <= 1'b0;
         s_r.ready <= 1'b0;
         s_r.slverr <= 1'b0;
         s_r.rdata <= 32'h0000_0000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state record
   assign prdata = s_r.rdata;
   assign pready = s_r.ready;
   assign pslverr = s_r.slverr;
   assign carry_out = s_r.carry;
   assign odd_channel_output = s_r.pin;
   assign channel_interrupt_flag = s_r.flag;
   assign channel_counter = s_r.cnt;

endmodule

// ==== ocd_pin_mon.sv ====
// Far-side model: circuitry that watches the compare pin.
// Assumes the pin is sampled on pclk; it only counts pulses.
`timescale 1ns/1ns
module ocd_pin_mon (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic [7:0] rises
);
   // ==========
   // Rising pin edges, counted one cycle late
   logic last_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_r <= 1'b0;
         rises <= 8'h00;
      end else begin
         last_r <= pin;
         if (pin && !last_r) begin
            rises <= rises + 8'h01;
         end
      end
   end
endmodule

// ==== ocd_channel_props.sv ====
// Checker for the compare channel, watching its ports only.
// Assumes zero-wait APB and compare values known from APB writes.
`timescale 1ns/1ns
module ocd_channel_chk #(
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic carry_out,
   input wire logic odd_channel_output,
   input wire logic channel_interrupt_flag,
   input wire logic [CNT_W-1:0] channel_counter
);
   // ==========
   // Shadow of the compare values, so matches can be predicted
   logic [CNT_W-1:0] pri_r;
   logic [CNT_W-1:0] sec_r;
   logic wr_ok;
   logic wr_con1;
   logic idle_w;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign wr_con1 = wr_ok && paddr == ocd_pkg::OFF_CON1;
   assign idle_w = pwdata[ocd_pkg::CON1_POL];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pri_r <= '0;
         sec_r <= '0;
      end else begin
         if (wr_ok && paddr == ocd_pkg::OFF_PRI) begin
            pri_r <= pwdata[CNT_W-1:0];
         end
         if (wr_ok && paddr == ocd_pkg::OFF_SEC) begin
            sec_r <= pwdata[CNT_W-1:0];
         end
      end
   end
   // ==========
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_cnt_step: assert property ($changed(channel_counter) |->
      channel_counter == $past(channel_counter) + 1'b1
      || channel_counter == '0) else $error("counter jumped");
   chk_carry_wrap: assert property (carry_out |->
      channel_counter == '0 || $past(channel_counter) == '0)
      else $error("carry without wrap");
   chk_pin_cause: assert property ($changed(odd_channel_output) |->
      $past(wr_con1) || $past(channel_counter) == pri_r
      || $past(channel_counter) == sec_r || channel_counter == '0)
      else $error("pin moved without match");
   chk_flag_cause: assert property ($rose(channel_interrupt_flag) |->
      $past(channel_counter) == pri_r || $past(channel_counter) == sec_r)
      else $error("flag set without match");
   chk_flag_clear: assert property ($fell(channel_interrupt_flag) |->
      $past(wr_ok && paddr == ocd_pkg::OFF_STAT && pwdata[0]))
      else $error("flag cleared without write");
   chk_off_clear: assert property (wr_con1 && pwdata[2:0] ==
      ocd_pkg::MODE_OFF |=> channel_counter == '0
      && odd_channel_output == $past(idle_w)) else $error("off mode");
   chk_ready_setup: assert property (psel && !penable |=> pready)
      else $error("pready late");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("pready held");
   chk_err_addr: assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("unmapped accepted");
   chk_read_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside access");
   cov_pin: cover property ($rose(odd_channel_output));
   cov_flag: cover property ($rose(channel_interrupt_flag));
   cov_carry: cover property (carry_out);
   cov_err: cover property (pslverr);
endmodule

bind ocd_channel ocd_channel_chk #(.CNT_W(CNT_W)) i_ocd_channel_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .carry_out(carry_out),
   .odd_channel_output(odd_channel_output),
   .channel_interrupt_flag(channel_interrupt_flag),
   .channel_counter(channel_counter));

// ==== output_compare_dedicated_timer_tb.sv ====
// Testbench for a cascaded pair of compare channels, driven over APB.
// Assumes tsel code 7 ticks every pclk; an even channel counts odd wraps.
`timescale 1ns/1ns
module output_compare_dedicated_timer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [4:0] tb_src = 5'h00;
   logic [30:0] sync_src = 31'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, carry_out, pin, flag, err, ok;
   logic [15:0] cnt;
   logic [7:0] rises;
   logic psel_hi = 1'b0;
   logic hi_sel = 1'b0;
   logic [31:0] prdata_hi;
   logic pready_hi, pslverr_hi;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   always #25 pclk = ~pclk;
   ocd_channel i_ocd_channel (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .time_base_src(tb_src), .sync_src(sync_src),
      .carry_in(1'b0), .carry_out(carry_out), .odd_channel_output(pin),
      .channel_interrupt_flag(flag), .channel_counter(cnt));
   ocd_channel #(.EVEN_CHANNEL(1'b1)) i_ocd_channel_hi (.pclk(pclk),
      .presetn(presetn), .psel(psel_hi), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata_hi), .pready(pready_hi), .pslverr(pslverr_hi),
      .time_base_src(tb_src), .sync_src(sync_src), .carry_in(carry_out),
      .carry_out(), .odd_channel_output(), .channel_interrupt_flag(),
      .channel_counter());
   ocd_pin_mon i_ocd_pin_mon (.pclk(pclk), .presetn(presetn), .pin(pin),
      .rises(rises));
   // ==========
   // Tasks
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input string s, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cmpb(input string s, input logic e, g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", s, e, g);
      end
   endtask
   // Holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, logic [15:0] d);
      @(posedge pclk);
      psel <= !hi_sel;
      psel_hi <= hi_sel;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while ((hi_sel ? pready_hi : pready) !== 1'b1);
      rd = hi_sel ? prdata_hi : prdata;
      err = hi_sel ? pslverr_hi : pslverr;
      psel <= 1'b0;
      psel_hi <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string s, input logic [7:0] a, logic [15:0] e);
      apb(1'b0, a, 16'h0000);
      cmp(s, e, rd[15:0]);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // 0 waits on the pin, 1 on the counter
   task automatic wait_until(input int which, input logic [15:0] v);
      ok = 1'b0;
      for (int i = 0; i < 300 && !ok; i++) begin
         tick(1);
         ok = ((which == 0) ? {15'h0000, pin} : cnt) === v;
      end
      cmpb("wait", 1'b1, ok);
   endtask
   task automatic pulse(input int k);
      @(posedge pclk);
      tb_src[k] <= 1'b1;
      tick(3);
      @(posedge pclk);
      tb_src[k] <= 1'b0;
      tick(3);
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         end_of_test();
      end
   end
   // ==========
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc("con1", 8'h00, 16'h0000);
      rdc("con2", 8'h04, 16'h0000);
      rdc("period", 8'h10, 16'hFFFF);
      rdc("counter", 8'h14, 16'h0000);
      apb(1'b1, 8'h20, 16'h1234);
      cmpb("unmapped", 1'b1, err);
      apb(1'b1, 8'h08, 16'h0005);
      apb(1'b1, 8'h0C, 16'h000C);
      apb(1'b1, 8'h10, 16'h0014);
      apb(1'b1, 8'h00, 16'h1C04);
      wait_until(1, 16'h0014);
      tick(1);
      cmp("wrap", 16'h0000, cnt);
      cmpb("carry", 1'b1, carry_out);
      apb(1'b1, 8'h00, 16'h1C01);
      wait_until(0, 16'h0001);
      cmp("single rise", 16'h0006, cnt);
      cmpb("single flag", 1'b1, flag);
      tick(50);
      cmp("one shot", 16'h0001, {8'h00, rises});
      apb(1'b1, 8'h18, 16'h0001);
      #1;
      cmpb("flag clear", 1'b0, flag);
      apb(1'b1, 8'h00, 16'h1C01);
      wait_until(0, 16'h0001);
      tick(1);
      cmp("rearm", 16'h0002, {8'h00, rises});
      apb(1'b1, 8'h18, 16'h0001);
      apb(1'b1, 8'h00, 16'h1C12);
      wait_until(0, 16'h0001);
      cmpb("flag early", 1'b0, flag);
      wait_until(0, 16'h0000);
      cmp("double fall", 16'h000D, cnt);
      cmpb("double flag", 1'b1, flag);
      wait_until(0, 16'h0001);
      cmp("repeat rise", 16'h0006, cnt);
      apb(1'b1, 8'h00, 16'h1C03);
      for (int i = 0; i < 2; i++) begin
         wait_until(0, (i == 0) ? 16'h0001 : 16'h0000);
         cmp("toggle", 16'h0006, cnt);
      end
      // Continuous single: rise on primary match, back to idle at wrap
      apb(1'b1, 8'h00, 16'h1C11);
      for (int i = 0; i < 3; i++) begin
         wait_until(0, (i == 1) ? 16'h0000 : 16'h0001);
         cmp("continuous", (i == 1) ? 16'h0000 : 16'h0006, cnt);
      end
      apb(1'b1, 8'h00, 16'h1C21);
      #1;
      cmpb("idle high", 1'b1, pin);
      wait_until(0, 16'h0000);
      apb(1'b1, 8'h00, 16'h0020);
      tick(2);
      cmp("off counter", 16'h0000, cnt);
      cmpb("off pin", 1'b1, pin);
      // Each pin source ticks only its own selection
      for (int k = 0; k < 5; k++) begin
         apb(1'b1, 8'h00, 16'h0000);
         apb(1'b1, 8'h00, 16'(k << 10) | 16'h0004);
         pulse(k);
         pulse(k);
         pulse((k + 1) % 5);
         cmp("time base", 16'h0002, cnt);
      end
      apb(1'b1, 8'h14, 16'h0009);
      rdc("counter read only", 8'h14, 16'h0002);
      apb(1'b1, 8'h10, 16'hFFFF);
      apb(1'b1, 8'h04, 16'h0001);
      apb(1'b1, 8'h00, 16'h0000);
      apb(1'b1, 8'h00, 16'h1C04);
      tick(40);
      @(posedge pclk);
      sync_src[0] <= 1'b1;
      wait_until(1, 16'h0000);
      tick(5);
      cmpb("sync runs", 1'b1, cnt != 16'h0000);
      apb(1'b1, 8'h04, 16'h0082);
      apb(1'b1, 8'h00, 16'h0000);
      apb(1'b1, 8'h00, 16'h1C04);
      tick(20);
      cmp("trigger hold", 16'h0000, cnt);
      apb(1'b0, 8'h18, 16'h0000);
      cmpb("not triggered", 1'b0, rd[2]);
      @(posedge pclk);
      sync_src[1] <= 1'b1;
      tick(10);
      cmpb("trigger run", 1'b1, cnt != 16'h0000);
      apb(1'b0, 8'h18, 16'h0000);
      cmpb("triggered", 1'b1, rd[2]);
      // Behaviour bit: one period per trigger, then a software trigger
      apb(1'b1, 8'h10, 16'h0008);
      apb(1'b1, 8'h00, 16'h0000);
      apb(1'b1, 8'h00, 16'h1C0C);
      tick(20);
      cmp("trigger once", 16'h0000, cnt);
      apb(1'b0, 8'h18, 16'h0000);
      cmpb("trigger cleared", 1'b0, rd[2]);
      apb(1'b1, 8'h04, 16'h00C2);
      tick(3);
      cmp("soft trigger", 16'h0003, cnt);
      // Cascade: even half counts the wraps of the odd half
      apb(1'b1, 8'h00, 16'h0000);
      hi_sel = 1'b1;
      apb(1'b1, 8'h04, 16'h0100);
      apb(1'b1, 8'h00, 16'h0004);
      hi_sel = 1'b0;
      apb(1'b1, 8'h04, 16'h0100);
      apb(1'b1, 8'h10, 16'h0003);
      apb(1'b1, 8'h00, 16'h1C04);
      tick(40);
      apb(1'b1, 8'h00, 16'h0000);
      hi_sel = 1'b1;
      rdc("cascade high", 8'h14, 16'h000A);
      hi_sel = 1'b0;
      end_of_test();
   end
endmodule
